// ==== logic/gss_top.sv ====
`timescale 1ns/1ps
`include "gss_consts.svh"

module gss_top
(
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    // Register bus
    input  wire gss_pkg::gss_apb_req_t apbReq,
    output      gss_pkg::gss_apb_rsp_t apbRsp,
    // PWM engine requests
    input  wire logic            highSideOnRequest,
    input  wire logic            lowSideOnRequest,
    // Gate driver stages
    output      gss_pkg::gss_drv_t highSideDrive,
    output      gss_pkg::gss_drv_t lowSideDrive,
    output      logic            lowSideOnGated,
    output      logic            highSideFastDischarge
);

    import gss_pkg::*;

    gss_state_t st_ff;
    gss_state_t nxt_st;

    function automatic logic addrMapped
    (
        input logic [11:0] addr
    );
        logic hit;
        hit = (addr == `GSS_OFS_CTRL)   ||
              (addr == `GSS_OFS_ONSEQ)  ||
              (addr == `GSS_OFS_OFFSEQ) ||
              (addr == `GSS_OFS_DEAD)   ||
              (addr == `GSS_OFS_STAT);
        return hit;
    endfunction

    function automatic logic [31:0] mergeBytes
    (
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = newVal[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Phase one sits in the top byte, phase four in the bottom byte.
    function automatic logic [4:0] phaseCurrent
    (
        input logic [31:0] seqReg,
        input logic [1:0]  ph
    );
        int top;
        top = 31 - `GSS_PHASE_BITS * int'(ph);
        return seqReg[top -: 5];
    endfunction

    function automatic logic [2:0] phaseDuration
    (
        input logic [31:0] seqReg,
        input logic [1:0]  ph
    );
        int top;
        top = 26 - `GSS_PHASE_BITS * int'(ph);
        return seqReg[top -: 3];
    endfunction

    // At this clock a 50 ns step cannot be resolved, so lengths round up.
    function automatic logic [3:0] phaseLoad
    (
        input logic [2:0] dur
    );
        int c;
        c = ((int'(dur) + 1) * `GSS_STEP_NS + `GSS_CLK_NS - 1) / `GSS_CLK_NS;
        return 4'(c - 1);
    endfunction

    always_comb
    begin
        logic [31:0] wr;
        logic [31:0] seqReg;
        logic        cmd;
        logic        seqEn;
        logic        fullSel;
        logic [4:0]  trim;
        logic        hsOff;
        logic        lsHeld;
        wr      = 32'h0000_0000;
        seqReg  = 32'h0000_0000;
        cmd     = 1'b0;
        seqEn   = 1'b0;
        fullSel = 1'b0;
        trim    = 5'h00;
        hsOff   = 1'b0;
        lsHeld  = 1'b0;
        nxt_st  = st_ff;

        // Bus answer is prepared in the setup cycle, so access never waits.
        nxt_st.rsp.pready = 1'b0;
        if (apbReq.psel && !apbReq.penable)
        begin
            nxt_st.rsp.pready  = 1'b1;
            nxt_st.rsp.pslverr = !addrMapped(apbReq.paddr);
            unique case (apbReq.paddr)
                `GSS_OFS_CTRL:
                begin
                    nxt_st.rsp.prdata = st_ff.bridgeDriverControlThree;
                end
                `GSS_OFS_ONSEQ:
                begin
                    nxt_st.rsp.prdata = st_ff.turnOnSequenceControl;
                end
                `GSS_OFS_OFFSEQ:
                begin
                    nxt_st.rsp.prdata = st_ff.turnOffSequenceControl;
                end
                `GSS_OFS_DEAD:
                begin
                    nxt_st.rsp.prdata = {24'h000000, st_ff.deadTime};
                end
                `GSS_OFS_STAT:
                begin
                    nxt_st.rsp.prdata = {24'h000000,
                                         st_ff.lowSideOnGated,
                                         st_ff.highSideFastDischarge,
                                         st_ff.drv[1].active,
                                         st_ff.drv[1].phase,
                                         st_ff.drv[0].active,
                                         st_ff.drv[0].phase};
                end
                default:
                begin
                    nxt_st.rsp.prdata = 32'h0000_0000;
                end
            endcase
        end

        if (apbReq.psel && apbReq.penable && st_ff.rsp.pready && apbReq.pwrite)
        begin
            unique case (apbReq.paddr)
                `GSS_OFS_CTRL:
                begin
                    wr = mergeBytes(st_ff.bridgeDriverControlThree,
                                    apbReq.pwdata, apbReq.pstrb);
                    nxt_st.bridgeDriverControlThree = wr & `GSS_CTRL_MASK;
                end
                `GSS_OFS_ONSEQ:
                begin
                    nxt_st.turnOnSequenceControl = mergeBytes(
                        st_ff.turnOnSequenceControl, apbReq.pwdata, apbReq.pstrb);
                end
                `GSS_OFS_OFFSEQ:
                begin
                    nxt_st.turnOffSequenceControl = mergeBytes(
                        st_ff.turnOffSequenceControl, apbReq.pwdata, apbReq.pstrb);
                end
                `GSS_OFS_DEAD:
                begin
                    wr = mergeBytes({24'h000000, st_ff.deadTime},
                                    apbReq.pwdata, apbReq.pstrb);
                    nxt_st.deadTime = wr[7:0];
                end
                default:
                begin
                    wr = 32'h0000_0000;
                end
            endcase
        end

        // The dead-time count is held full while the high side is on and
        // runs down once it is released.
        hsOff = !highSideOnRequest;
        if (highSideOnRequest)
        begin
            nxt_st.deadCnt = st_ff.deadTime;
        end
        else if (st_ff.deadCnt != 8'h00)
        begin
            nxt_st.deadCnt = st_ff.deadCnt - 8'h01;
        end
        lsHeld = lowSideOnRequest && (!hsOff || st_ff.deadCnt != 8'h00);
        nxt_st.lowSideOnGated = lowSideOnRequest && !lsHeld;
        nxt_st.highSideFastDischarge = lsHeld && hsOff;

        for (int i = 0; i < 2; i++)
        begin
            cmd = (i == 0) ? highSideOnRequest : st_ff.lowSideOnGated;
            if (cmd)
            begin
                seqEn   = st_ff.bridgeDriverControlThree[`GSS_BIT_ON_EN];
                fullSel = st_ff.bridgeDriverControlThree[`GSS_BIT_CHG_FULL];
                trim    = st_ff.bridgeDriverControlThree[`GSS_CHG_LSB +: 5];
                seqReg  = st_ff.turnOnSequenceControl;
            end
            else
            begin
                seqEn   = st_ff.bridgeDriverControlThree[`GSS_BIT_OFF_EN];
                fullSel = st_ff.bridgeDriverControlThree[`GSS_BIT_DIS_FULL];
                trim    = st_ff.bridgeDriverControlThree[`GSS_DIS_LSB +: 5];
                seqReg  = st_ff.turnOffSequenceControl;
            end
            nxt_st.chan[i].lastCmd = cmd;

            if (cmd != st_ff.chan[i].lastCmd)
            begin
                nxt_st.drv[i].gateOn    = cmd;
                nxt_st.drv[i].charging  = cmd;
                nxt_st.drv[i].fullRange = fullSel;
                nxt_st.drv[i].phase     = 2'h0;
                if (seqEn)
                begin
                    nxt_st.chan[i].seq        = GSS_RUN;
                    nxt_st.chan[i].cnt        = phaseLoad(phaseDuration(seqReg, 2'h0));
                    nxt_st.drv[i].currentCode = phaseCurrent(seqReg, 2'h0);
                    nxt_st.drv[i].active      = 1'b1;
                end
                else
                begin
                    nxt_st.chan[i].seq        = GSS_IDLE;
                    nxt_st.chan[i].cnt        = 4'h0;
                    nxt_st.drv[i].currentCode = trim;
                    nxt_st.drv[i].active      = 1'b0;
                end
            end
            else if (st_ff.chan[i].seq == GSS_RUN)
            begin
                if (st_ff.chan[i].cnt != 4'h0)
                begin
                    nxt_st.chan[i].cnt = st_ff.chan[i].cnt - 4'h1;
                end
                else if (st_ff.drv[i].phase == `GSS_LAST_PHASE)
                begin
                    // The last phase current stays applied until the next edge or until the sequence enable bit is cleared.
                    nxt_st.chan[i].seq   = GSS_IDLE;
                    nxt_st.drv[i].active = 1'b0;
                end
                else
                begin
                    nxt_st.drv[i].phase = st_ff.drv[i].phase + 2'h1;
                    nxt_st.chan[i].cnt = phaseLoad(
                        phaseDuration(seqReg, st_ff.drv[i].phase + 2'h1));
                    nxt_st.drv[i].currentCode = phaseCurrent(
                        seqReg, st_ff.drv[i].phase + 2'h1);
                end
            end
            else if (!seqEn && !st_ff.drv[i].active)
            begin
                // Trim edits act at once while no sequence is in use.
                nxt_st.drv[i].currentCode = trim;
                nxt_st.drv[i].fullRange   = fullSel;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_ff          <= '0;
            st_ff.deadTime <= `GSS_DEAD_RST;
            st_ff.deadCnt  <= `GSS_DEAD_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign apbRsp                = st_ff.rsp;
    assign highSideDrive         = st_ff.drv[0];
    assign lowSideDrive          = st_ff.drv[1];
    assign lowSideOnGated        = st_ff.lowSideOnGated;
    assign highSideFastDischarge = st_ff.highSideFastDischarge;

endmodule

// ==== logic/gss_consts.svh ====
`ifndef GSS_CONSTS_SVH
`define GSS_CONSTS_SVH

// Overview of operation
// - Control bit 15 enables turn-off sequencer.
// - Control bit 7 enables turn-on sequencer.
// - Control bit 14 selects full discharge range.
// - Control bit 6 selects full charge range.
// - Half range halves every current code.
// - Phase codes share the trim code encoding.
// - Turn-on register holds four current/duration phases.
// - Turn-off register holds four current/duration phases.
// - Duration code n lasts (n+1) times 50 ns; here rounded up to whole 100 ns clocks.
// - Codes 01100/01001 give 130/98 mA full range.
// - Codes 00011/01111 give 31/160 mA full range.
// - Low-side request passes through cross-conduction guard.
// - Guard uses a software programmable dead-time counter.
// - Low-side on waits out dead time after high-off.
// - Fast discharge high side while low side held in dead time after high-off.

// Register byte addresses.
`define GSS_OFS_CTRL       12'h000
`define GSS_OFS_ONSEQ      12'h004
`define GSS_OFS_OFFSEQ     12'h008
`define GSS_OFS_DEAD       12'h00C
`define GSS_OFS_STAT       12'h010

// Control register fields.
`define GSS_BIT_OFF_EN     15
`define GSS_BIT_DIS_FULL   14
`define GSS_BIT_ON_EN      7
`define GSS_BIT_CHG_FULL   6
`define GSS_CHG_LSB        0
`define GSS_DIS_LSB        8
`define GSS_CTRL_MASK      32'h0000DFDF

// Reset values.
`define GSS_DEAD_RST       8'h0A

// Sequencer layout and timing.
`define GSS_PHASE_BITS     8
`define GSS_LAST_PHASE     2'h3
`define GSS_STEP_NS        50
`define GSS_CLK_NS         100

`endif

// ==== logic/gss_pkg.sv ====
package gss_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } gss_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } gss_apb_rsp_t;

    typedef enum logic [0:0] {
        GSS_IDLE,
        GSS_RUN
    } gss_seq_t;

    typedef struct packed {
        logic       gateOn;
        logic       charging;
        logic       fullRange;
        logic [4:0] currentCode;
        logic [1:0] phase;
        logic       active;
    } gss_drv_t;

    typedef struct packed {
        gss_seq_t   seq;
        logic       lastCmd;
        logic [3:0] cnt;
    } gss_chan_t;

    typedef struct packed {
        logic [31:0]        bridgeDriverControlThree;
        logic [31:0]        turnOnSequenceControl;
        logic [31:0]        turnOffSequenceControl;
        logic [7:0]         deadTime;
        logic [7:0]         deadCnt;
        logic               lowSideOnGated;
        logic               highSideFastDischarge;
        gss_chan_t [1:0]    chan;
        gss_drv_t [1:0]     drv;
        gss_apb_rsp_t       rsp;
    } gss_state_t;

endpackage

// ==== testbench/gss_top_properties.sv ====
`timescale 1ns/1ps
module gss_top_properties
(
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst_b,
    // Register bus
    input wire gss_pkg::gss_apb_req_t apbReq,
    input wire gss_pkg::gss_apb_rsp_t apbRsp,
    // Requests and drives
    input wire logic                  highSideOnRequest,
    input wire logic                  lowSideOnRequest,
    input wire gss_pkg::gss_drv_t     highSideDrive,
    input wire gss_pkg::gss_drv_t     lowSideDrive,
    input wire logic                  lowSideOnGated,
    input wire logic                  highSideFastDischarge
);
    import gss_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    logic lsFree;
    assign lsFree = lowSideOnRequest && !highSideOnRequest;
    gated_needs_ls_a: assert property (lowSideOnGated |-> $past(lsFree))
        else $error("low side passed without a free request");
    hs_masks_ls_a: assert property (highSideOnRequest |=> !lowSideOnGated)
        else $error("low side passed while high side on");
    hs_stops_fd_a: assert property (highSideOnRequest |=> !highSideFastDischarge)
        else $error("fast discharge while high side on");
    guard_split_a: assert property ($past(lsFree)
        |-> lowSideOnGated ^ highSideFastDischarge)
        else $error("held low side without fast discharge");
    guard_excl_a: assert property (!(lowSideOnGated && highSideFastDischarge))
        else $error("fast discharge while low side passed");
    hs_gate_follows_a: assert property (highSideDrive.gateOn == $past(highSideOnRequest))
        else $error("high side gate does not follow its request");
    ls_gate_follows_a: assert property (lowSideDrive.gateOn == $past(lowSideOnGated))
        else $error("low side gate does not follow the masked command");
    phase_order_a: assert property (highSideDrive.active && $past(highSideDrive.active)
        && $stable(highSideDrive.gateOn) && $changed(highSideDrive.phase)
        |-> highSideDrive.phase == $past(highSideDrive.phase) + 2'h1)
        else $error("phase skipped");
    seq_end_a: assert property ($fell(highSideDrive.active)
        && $stable(highSideDrive.gateOn) |-> highSideDrive.phase == 2'h3)
        else $error("sequence ended before last phase");
    cover property ($rose(lowSideOnGated));
    cover property ($rose(highSideFastDischarge));
    cover property ($fell(highSideDrive.active));
endmodule
bind gss_top gss_top_properties gss_top_properties_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .apbReq(apbReq), .apbRsp(apbRsp), .highSideOnRequest(highSideOnRequest),
    .lowSideOnRequest(lowSideOnRequest), .highSideDrive(highSideDrive),
    .lowSideDrive(lowSideDrive), .lowSideOnGated(lowSideOnGated),
    .highSideFastDischarge(highSideFastDischarge));

// ==== testbench/gss_pwm_model.sv ====
`timescale 1ns/1ps
module gss_pwm_model
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // Pattern
    input wire logic       run,
    input wire logic [3:0] gap,
    // Requests
    output logic           highSideOnRequest,
    output logic           lowSideOnRequest
);
    logic [5:0] tick;
    // A gap of zero hands over directly, the case the guard must catch.
    always_ff @(posedge clk_sys)
    begin
        tick <= (rst_b && run) ? tick + 6'h01 : 6'h00;
        highSideOnRequest <= rst_b && run && tick < 6'h10;
        lowSideOnRequest <= rst_b && run && tick >= 6'h10 + {2'h0, gap} && tick < 6'h1E;
    end
endmodule

// ==== testbench/test_gss_top.sv ====
`timescale 1ns/1ps
`include "gss_consts.svh"
module test_gss_top;
    import gss_pkg::*;
    logic         clk_sys;
    logic         rst_b;
    gss_apb_req_t apbReq;
    gss_apb_rsp_t apbRsp;
    gss_drv_t     hsDrv;
    gss_drv_t     lsDrv;
    logic         hsReq;
    logic         lsReq;
    logic         gated;
    logic         fastDis;
    logic         run;
    logic [3:0]   gap;
    logic [31:0]  rd;
    logic         err;
    int           n_errors;
    int           n_tests;
    int           cycles;

    gss_top gss_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
        .highSideOnRequest(hsReq), .lowSideOnRequest(lsReq), .highSideDrive(hsDrv),
        .lowSideDrive(lsDrv), .lowSideOnGated(gated), .highSideFastDischarge(fastDis));
    gss_pwm_model gss_pwm_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .run(run), .gap(gap),
        .highSideOnRequest(hsReq), .lowSideOnRequest(lsReq));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'hF};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do @(posedge clk_sys);
        while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask

    task automatic reg_check;
        apb(1'b0, `GSS_OFS_DEAD, 32'h0);
        chk(rd, 32'(`GSS_DEAD_RST));
        apb(1'b1, `GSS_OFS_CTRL, 32'hFFFFFFFF);
        apb(1'b0, `GSS_OFS_CTRL, 32'h0);
        chk(rd, `GSS_CTRL_MASK);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `GSS_OFS_STAT, 32'hFFFFFFFF);
        chk(32'(err), 32'h0);
        apb(1'b0, `GSS_OFS_STAT, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `GSS_OFS_DEAD, 32'h3);
        apb(1'b0, `GSS_OFS_DEAD, 32'h0);
        chk(rd, 32'h3);
    endtask

    // Dead time is 3 here; the low side may only pass after max(dead, gap) + 1 edges.
    task automatic guard_check(input logic [3:0] g);
        int n;
        logic fd;
        n = 0;
        fd = 1'b0;
        gap <= g;
        run <= 1'b1;
        do @(negedge clk_sys);
        while (hsReq !== 1'b1 && ++n < 50);
        do @(negedge clk_sys);
        while (hsReq !== 1'b0 && ++n < 50);
        n = 0;
        while (gated !== 1'b1 && n < 40)
        begin
            fd = fd | fastDis;
            @(negedge clk_sys);
            n++;
        end
        chk(n, (g > 3) ? g + 1 : 4);
        chk(32'(fd), 32'(g < 3));
        chk(32'(lsDrv.gateOn), 32'h0);
        @(negedge clk_sys);
        chk(32'({lsDrv.gateOn, lsDrv.charging}), 32'h3);
        run <= 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic seq_check(input logic on, input logic [31:0] sr);
        int n;
        int b;
        logic [9:0] got;
        n = 0;
        do @(negedge clk_sys);
        while (!(hsDrv.active === 1'b1 && hsDrv.gateOn === on) && ++n < 100);
        for (int p = 0; p < 4; p++)
        begin
            b = 8 * (3 - p);
            repeat (((sr[b +: 3] + 1) * 50 + 99) / 100)
            begin
                got = {hsDrv.fullRange, hsDrv.charging, hsDrv.currentCode,
                       hsDrv.phase, hsDrv.active};
                chk(32'(got[9:8]), 32'({1'b1, on}));
                chk(32'(got[7:0]), 32'({sr[b + 3 +: 5], 2'(p), 1'b1}));
                @(negedge clk_sys);
            end
        end
        chk(32'(hsDrv.active), 32'h0);
    endtask

    task automatic seq_pair(input logic [31:0] onReg, input logic [31:0] offReg);
        apb(1'b1, `GSS_OFS_ONSEQ, onReg);
        apb(1'b1, `GSS_OFS_OFFSEQ, offReg);
        run <= 1'b1;
        seq_check(1'b1, onReg);
        seq_check(1'b0, offReg);
        run <= 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic trim_check(input logic on, input logic [4:0] code);
        int n;
        n = 0;
        do @(negedge clk_sys);
        while (hsDrv.gateOn !== on && ++n < 100);
        chk(32'({hsDrv.gateOn, hsDrv.fullRange, hsDrv.active}), 32'({on, 2'b00}));
        chk(32'(hsDrv.currentCode), 32'(code));
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        apbReq = '0;
        run = 1'b0;
        gap = 4'h0;
        cycles = 0;
        n_errors = 0;
        n_tests = 0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        reg_check();
        guard_check(4'h0);
        guard_check(4'h8);
        apb(1'b1, `GSS_OFS_CTRL, 32'h0000CAC5);
        seq_pair(32'h634B1B63, 32'h671B4B63);
        seq_pair(32'h08121C26, 32'h79333D47);
        apb(1'b1, `GSS_OFS_CTRL, 32'h00000A05);
        run <= 1'b1;
        trim_check(1'b1, 5'h05);
        trim_check(1'b0, 5'h0A);
        conclude();
    end
endmodule
